// [include/bpm_pkg.sv]
// Constants and carrier types for the board page map and I/O glue.
// Assumes an 8-bit I/O port space reached by one-cycle read/write strobes.
// How it works
// [RULE_01] Bit 7 picks SRAM or ROM low half
// [RULE_02] Bits 6:3 drive A18:A15, complemented to SRAM
// [RULE_03] Bits 2:0 never touch the mapping
// [RULE_04] Reset clears the page map register
// [RULE_05] High half always SRAM page zero
// [RULE_06] Read of kick port retriggers watchdog
// [RULE_07] Missed kick resets board when jumper allows
// [RULE_08] Software kicks within the intervention time
// [RULE_09] EEPROM wires ride serial modem lines
// [RULE_10] EEPROM address selects tied low
// [RULE_11] Software leaves EEPROM bytes 0..31 alone
// [RULE_12] Battery bit 3 shows charge above threshold
// [RULE_13] Switch n+1 appears on data bit n
// [RULE_14] Switch ON reads zero, OFF reads one
// [RULE_15] Switch read also kicks the watchdog
// [RULE_16] Run/debug jumper drives channel B sync
// [RULE_17] Page map write also drives flash control
// [RULE_18] Mapping changes after the write completes
package bpm_pkg;
    localparam logic [7:0] BPM_PAGE_MAP_ADDR = 8'hf8;
    localparam logic [7:0] BPM_BATTERY_ADDR = 8'hf8;
    localparam logic [7:0] BPM_SWITCH_ADDR = 8'hfc;
    localparam int BPM_SRAM_SEL_BIT = 7;
    localparam int BPM_PAGE_HI_BIT = 6;
    localparam int BPM_PAGE_LO_BIT = 3;
    localparam int BPM_FLASH_CLK_BIT = 0;
    localparam int BPM_FLASH_CS2_BIT = 1;
    localparam int BPM_FLASH_CS1_BIT = 2;
    localparam int BPM_BATTERY_BIT = 3;
    localparam logic [7:0] BPM_PAGE_MAP_RST = 8'h00;
    localparam logic [2:0] BPM_EEPROM_ADDR_SEL = 3'h0;
    localparam int BPM_CLK_HZ = 50000000;
    localparam int BPM_WDT_TIME_MS = 1400;
    localparam int BPM_WDT_CYCLES = BPM_CLK_HZ / 1000 * BPM_WDT_TIME_MS;

    typedef struct packed {
        logic rom_cs;
        logic sram_low_cs;
        logic sram_high_cs;
        logic [3:0] rom_addr_hi;
        logic [3:0] sram_addr_hi;
    } bpm_mem_t;

    typedef struct packed {
        logic [7:0] page_map;
        logic [1:0] sw_sync;
        logic [7:0] sw_meta;
        logic [7:0] sw_q;
        logic [1:0] bat_meta;
        logic [1:0] jmp_meta;
        logic [1:0] wdj_meta;
        logic [1:0] sda_meta;
        logic [7:0] rdata;
        logic [31:0] wdt_cnt;
        logic wdt_reset;
        logic wdt_kick;
        bpm_mem_t mem;
        logic eeprom_sda_in;
        logic sync_b;
    } bpm_state_t;
endpackage

// [rtl/bpm_top.sv]
// Page map register, watchdog retrigger and option input glue.
// Assumes io strobes are one-cycle pulses synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bpm_top
    import bpm_pkg::*;
#(
    parameter int WDT_CYCLES = BPM_WDT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic mem_a15,
    input wire logic [7:0] option_switch_n,
    input wire logic battery_ok,
    input wire logic run_debug_jumper,
    input wire logic watchdog_reset_jumper,
    input wire logic eeprom_sda_pin,
    input wire logic serial_a_terminal_ready,
    input wire logic serial_b_terminal_ready,
    output logic rom_cs,
    output logic sram_low_cs,
    output logic sram_high_cs,
    output logic [3:0] rom_addr_hi,
    output logic [3:0] sram_addr_hi,
    output logic watchdog_kick,
    output logic board_reset,
    output logic flash_clk,
    output logic flash_cs1,
    output logic flash_cs2,
    output logic eeprom_scl,
    output logic eeprom_sda_oe,
    output logic eeprom_sda_out,
    output logic [2:0] eeprom_addr_sel,
    output logic serial_a_sync_line,
    output logic serial_b_sync_line
);
    bpm_state_t st_r;
    bpm_state_t st_nxt;
    logic wdt_en;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // ***************************************************************
    // Input sync, decode and next state
    // ***************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.sw_meta = option_switch_n;
        st_nxt.sw_q = st_r.sw_meta;
        st_nxt.bat_meta = {st_r.bat_meta[0], battery_ok};
        st_nxt.jmp_meta = {st_r.jmp_meta[0], run_debug_jumper};
        st_nxt.wdj_meta = {st_r.wdj_meta[0], watchdog_reset_jumper};
        st_nxt.sda_meta = {st_r.sda_meta[0], eeprom_sda_pin};
        st_nxt.sw_sync = 2'h0;
        if (io_wr && hit(io_addr, BPM_PAGE_MAP_ADDR)) begin
            st_nxt.page_map = io_wdata; // [RULE_17] [RULE_18]
        end
        st_nxt.rdata = 8'h00;
        st_nxt.wdt_kick = 1'b0;
        if (io_rd && hit(io_addr, BPM_SWITCH_ADDR)) begin
            st_nxt.rdata = st_r.sw_q; // [RULE_13] [RULE_14]
            st_nxt.wdt_kick = 1'b1; // [RULE_06] [RULE_15]
        end else if (io_rd && hit(io_addr, BPM_BATTERY_ADDR)) begin
            st_nxt.rdata[BPM_BATTERY_BIT] = st_r.bat_meta[1]; // [RULE_12]
        end
        if (st_nxt.wdt_kick) begin
            st_nxt.wdt_cnt = 32'h0;
        end else if (st_r.wdt_cnt < 32'(WDT_CYCLES)) begin
            st_nxt.wdt_cnt = st_r.wdt_cnt + 32'h1;
        end
        wdt_en = st_r.wdj_meta[1];
        st_nxt.wdt_reset = wdt_en &&
            (st_r.wdt_cnt >= 32'(WDT_CYCLES)); // [RULE_07]
        st_nxt.mem.rom_cs = !mem_a15 && // [RULE_01]
            !st_nxt.page_map[BPM_SRAM_SEL_BIT];
        st_nxt.mem.sram_low_cs = !mem_a15 && st_nxt.page_map[BPM_SRAM_SEL_BIT];
        st_nxt.mem.sram_high_cs = mem_a15; // [RULE_05]
        st_nxt.mem.rom_addr_hi = // [RULE_02] [RULE_03]
            st_nxt.page_map[BPM_PAGE_HI_BIT:BPM_PAGE_LO_BIT];
        st_nxt.mem.sram_addr_hi = mem_a15 ? 4'hf : // [RULE_02] [RULE_05]
            ~st_nxt.page_map[BPM_PAGE_HI_BIT:BPM_PAGE_LO_BIT];
        st_nxt.eeprom_sda_in = st_r.sda_meta[1]; // [RULE_09]
        st_nxt.sync_b = st_r.jmp_meta[1]; // [RULE_16]
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_r <= '0; // [RULE_04]
            st_r.page_map <= BPM_PAGE_MAP_RST;
            st_r.mem.rom_cs <= 1'b1;
            st_r.mem.sram_addr_hi <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ***************************************************************
    // EEPROM lines
    // ***************************************************************
    // Low outputs follow registered state; SDA is open drain, low only
    logic scl_r;
    logic sda_oe_r;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            scl_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            scl_r <= serial_a_terminal_ready; // [RULE_09]
            sda_oe_r <= serial_b_terminal_ready;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign io_rdata = st_r.rdata;
    assign rom_cs = st_r.mem.rom_cs;
    assign sram_low_cs = st_r.mem.sram_low_cs;
    assign sram_high_cs = st_r.mem.sram_high_cs;
    assign rom_addr_hi = st_r.mem.rom_addr_hi;
    assign sram_addr_hi = st_r.mem.sram_addr_hi;
    assign watchdog_kick = st_r.wdt_kick;
    assign board_reset = st_r.wdt_reset;
    assign flash_clk = st_r.page_map[BPM_FLASH_CLK_BIT];
    assign flash_cs2 = st_r.page_map[BPM_FLASH_CS2_BIT];
    assign flash_cs1 = st_r.page_map[BPM_FLASH_CS1_BIT];
    assign eeprom_scl = scl_r;
    assign eeprom_sda_oe = sda_oe_r;
    assign eeprom_sda_out = 1'b0;
    assign eeprom_addr_sel = BPM_EEPROM_ADDR_SEL; // [RULE_10]
    assign serial_a_sync_line = st_r.eeprom_sda_in;
    assign serial_b_sync_line = st_r.sync_b;

    // ***************************************************************
    // Checks
    // ***************************************************************
    AST_RESET_MAP: assert property ( // [RULE_04]
        @(posedge clk_sys) !rstn |=> rom_cs && !sram_low_cs &&
        !sram_high_cs && rom_addr_hi == 4'h0 && sram_addr_hi == 4'hf &&
        !flash_clk && !flash_cs1 && !flash_cs2)
        else $error("page map not cleared");
    AST_WRITE_MAP: assert property ( // [RULE_18]
        @(posedge clk_sys) disable iff (!rstn)
        io_wr && io_addr == BPM_PAGE_MAP_ADDR |=> ##1
        rom_addr_hi == $past(io_wdata[6:3], 2))
        else $error("page bits not applied");
    AST_SRAM_SEL: assert property ( // [RULE_01]
        @(posedge clk_sys) disable iff (!rstn)
        !mem_a15 |=> sram_low_cs == st_r.page_map[BPM_SRAM_SEL_BIT] &&
        rom_cs == !sram_low_cs)
        else $error("low half select wrong");
    AST_SRAM_INV: assert property ( // [RULE_02]
        @(posedge clk_sys) disable iff (!rstn)
        !sram_high_cs |-> sram_addr_hi == ~rom_addr_hi)
        else $error("sram address not complemented");
    AST_HIGH_HALF: assert property ( // [RULE_05]
        @(posedge clk_sys) disable iff (!rstn)
        mem_a15 |=> sram_high_cs && !rom_cs && sram_addr_hi == 4'hf)
        else $error("high half not sram page 0");
    AST_LOW_BITS: assert property ( // [RULE_03]
        @(posedge clk_sys) disable iff (!rstn)
        io_wr && io_addr == BPM_PAGE_MAP_ADDR &&
        io_wdata[7:3] == st_r.page_map[7:3] |=> $stable(rom_addr_hi))
        else $error("low bits moved mapping");
    AST_KICK: assert property ( // [RULE_06]
        @(posedge clk_sys) disable iff (!rstn)
        io_rd && io_addr == BPM_SWITCH_ADDR |=> watchdog_kick)
        else $error("read did not kick");
    AST_SWITCH: assert property ( // [RULE_13]
        @(posedge clk_sys) disable iff (!rstn)
        io_rd && io_addr == BPM_SWITCH_ADDR |=>
        io_rdata == $past(st_r.sw_q))
        else $error("switch read wrong");
    AST_WDT: assert property ( // [RULE_07]
        @(posedge clk_sys) disable iff (!rstn)
        board_reset |-> $past(st_r.wdj_meta[1]))
        else $error("watchdog reset without jumper");
    AST_FLASH: assert property ( // [RULE_17]
        @(posedge clk_sys) disable iff (!rstn)
        io_wr && io_addr == BPM_PAGE_MAP_ADDR |=>
        flash_cs1 == $past(io_wdata[2]))
        else $error("flash control not written");
    AST_BATTERY: assert property ( // [RULE_12]
        @(posedge clk_sys) disable iff (!rstn)
        io_rd && io_addr == BPM_BATTERY_ADDR |=>
        io_rdata[BPM_BATTERY_BIT] == $past(battery_ok, 3))
        else $error("battery bit wrong");
    AST_RDATA_IDLE: assert property ( // [RULE_13]
        @(posedge clk_sys) disable iff (!rstn)
        !(io_rd && (io_addr == BPM_SWITCH_ADDR ||
        io_addr == BPM_BATTERY_ADDR)) |=> io_rdata == 8'h00)
        else $error("read data not idle");
    AST_EEPROM_LINES: assert property ( // [RULE_09]
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn) |->
        eeprom_scl == $past(serial_a_terminal_ready) &&
        eeprom_sda_oe == $past(serial_b_terminal_ready))
        else $error("eeprom lines not following modem lines");
    AST_SYNC_A: assert property ( // [RULE_09]
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn, 3) && $past(rstn, 2) && $past(rstn) |->
        serial_a_sync_line == $past(eeprom_sda_pin, 3))
        else $error("sda not seen on channel a sync");
    AST_SYNC_B: assert property ( // [RULE_16]
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn, 3) && $past(rstn, 2) && $past(rstn) |->
        serial_b_sync_line == $past(run_debug_jumper, 3))
        else $error("jumper not seen on channel b sync");
    COV_ROM: cover property (@(posedge clk_sys) rom_cs && rom_addr_hi == 4'hf);
    COV_SRAM: cover property (@(posedge clk_sys) sram_low_cs);
    COV_KICK: cover property (@(posedge clk_sys) watchdog_kick);
    COV_WDT: cover property (@(posedge clk_sys) board_reset);
endmodule
`default_nettype wire

// [verification/bpm_cpu_model.sv]
// Processor model issuing I/O reads and writes.
// Assumes strobes are sampled on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bpm_cpu_model (
    input wire logic clk_sys,
    output logic [7:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic watchdog_kick
);
    // ****
    // Bus cycles, no EEPROM data writes
    // ****
    initial begin
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_rd = 1'b0;
        io_wr = 1'b0;
    end
    task automatic io_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys) #1 io_addr = a;
        io_wdata = v;
        io_wr = 1'b1;
        @(posedge clk_sys) #1 io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~v;
    endtask
    task automatic io_read(input logic [7:0] a, output logic [7:0] v,
        output logic k);
        @(posedge clk_sys) #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge clk_sys) #1 io_rd = 1'b0;
        io_addr = ~a;
        v = io_rdata;
        k = watchdog_kick;
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the page map and I/O glue.
// Assumes bpm_cpu_model; watchdog limit cut to 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bpm_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b0, mem_a15 = 1'b0, battery_ok = 1'b0;
    logic run_debug_jumper = 1'b0, watchdog_reset_jumper = 1'b0;
    logic serial_a_terminal_ready = 1'b0, serial_b_terminal_ready = 1'b0;
    logic sda_drv = 1'b1, io_rd, io_wr, k, rom_cs, sram_low_cs, sram_high_cs;
    logic [7:0] option_switch_n = 8'hff, io_addr, io_wdata, io_rdata, d, v;
    logic watchdog_kick, board_reset, flash_clk, flash_cs1, flash_cs2;
    logic eeprom_scl, eeprom_sda_oe, eeprom_sda_out;
    logic serial_a_sync_line, serial_b_sync_line;
    logic [3:0] rom_addr_hi, sram_addr_hi;
    logic [2:0] eeprom_addr_sel;
    logic [7:0] pm [9] = '{8'h00, 8'h08, 8'h78, 8'h80, 8'h88, 8'hf8,
        8'hff, 8'h07, 8'hcd};
    wire eeprom_sda_pin;
    int failures = 0, tests_run = 0;
    // ****
    // Harness
    // ****
    assign eeprom_sda_pin = eeprom_sda_oe ? 1'b0 : sda_drv;
    always #10 clk_sys = ~clk_sys;
    bpm_top #(.WDT_CYCLES(50)) u_bpm_top (.clk_sys, .rstn, .io_addr,
        .io_rd, .io_wr, .io_wdata, .io_rdata, .mem_a15, .option_switch_n,
        .battery_ok, .run_debug_jumper, .watchdog_reset_jumper,
        .eeprom_sda_pin, .serial_a_terminal_ready, .serial_b_terminal_ready,
        .rom_cs, .sram_low_cs, .sram_high_cs, .rom_addr_hi, .sram_addr_hi,
        .watchdog_kick, .board_reset, .flash_clk, .flash_cs1, .flash_cs2,
        .eeprom_scl, .eeprom_sda_oe, .eeprom_sda_out, .eeprom_addr_sel,
        .serial_a_sync_line, .serial_b_sync_line);
    bpm_cpu_model u_bpm_cpu_model (.clk_sys, .io_addr, .io_rd, .io_wr,
        .io_wdata, .io_rdata, .watchdog_kick);
    task automatic chk(input string n, input logic [15:0] s,
        input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400us;
        failures++;
        end_of_test();
    end
    // ****
    // Tests
    // ****
    initial begin
        step(20);
        rstn = 1'b1;
        step(1);
        chk("reset map", {rom_cs, sram_low_cs, rom_addr_hi, sram_addr_hi,
            flash_cs1, flash_cs2, flash_clk}, 16'h1078);
        chk("addr sel", eeprom_addr_sel, 16'h0);
        foreach (pm[i]) begin
            v = pm[i];
            mem_a15 = 1'b0;
            u_bpm_cpu_model.io_write(BPM_PAGE_MAP_ADDR, v);
            chk("flash", {flash_cs1, flash_cs2, flash_clk},
                v[2:0]);
            step(1);
            chk("low sel", {rom_cs, sram_low_cs},
                {~v[7], v[7]});
            chk("low page", {rom_addr_hi, sram_addr_hi},
                {v[6:3], ~v[6:3]});
            mem_a15 = 1'b1;
            step(1);
            chk("high", {rom_cs, sram_low_cs, sram_high_cs}, 3'h1);
        end
        $display("map test end");
        for (int j = 0; j < 2; j++) begin
            option_switch_n = j ? 8'ha5 : 8'h5a;
            battery_ok = j[0];
            step(3);
            u_bpm_cpu_model.io_read(BPM_SWITCH_ADDR, d, k);
            chk("switch", d, option_switch_n);
            chk("kick", k, 1'b1);
            u_bpm_cpu_model.io_read(BPM_BATTERY_ADDR, d, k);
            chk("battery", {d[3], k}, {j[0], 1'b0});
        end
        u_bpm_cpu_model.io_read(8'h40, d, k);
        chk("unmapped", {d, k}, 9'h0);
        $display("read test end");
        for (int j = 0; j < 4; j++) begin
            serial_a_terminal_ready = j[0];
            serial_b_terminal_ready = j[1];
            run_debug_jumper = j[0];
            sda_drv = j[0];
            step(6);
            chk("eeprom", {eeprom_scl, eeprom_sda_oe, eeprom_sda_out},
                {j[0], j[1], 1'b0});
            chk("sync a", serial_a_sync_line, j[0] & ~j[1]);
            chk("sync b", serial_b_sync_line, j[0]);
        end
        $display("line test end");
        watchdog_reset_jumper = 1'b1;
        repeat (4) begin
            u_bpm_cpu_model.io_read(BPM_SWITCH_ADDR, d, k);
            step(30);
            chk("no reset", board_reset, 1'b0);
        end
        step(70);
        chk("wdt reset", board_reset, 1'b1);
        u_bpm_cpu_model.io_read(BPM_SWITCH_ADDR, d, k);
        step(1);
        chk("wdt clear", board_reset, 1'b0);
        watchdog_reset_jumper = 1'b0;
        step(100);
        chk("jumper off", board_reset, 1'b0);
        $display("watchdog test end");
        end_of_test();
    end
endmodule
`default_nettype wire
